/* File: brownout_reset_sequencer_regs.svh */
// Purpose : Register map, field positions and timing constants of the reset sequencer
// Assumes : 32-bit classic Wishbone, byte addresses, one register per aligned word
// Notes   : Definitions only
`ifndef BROWNOUT_RESET_SEQUENCER_REGS_SVH
`define BROWNOUT_RESET_SEQUENCER_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_RESET_CTRL      6'h00
`define REG_OSC_CTRL        6'h04
`define REG_CONFIG          6'h08
`define REG_IRQ_STATUS      6'h0C
`define REG_IRQ_MASK        6'h10
`define REG_TIMING          6'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RESET_CTRL_BOR_BIT  1
`define RESET_CTRL_POR_BIT  0
`define OSC_CTRL_LOCK_BIT   5
`define CFG_OSC_SEL_LSB     0
`define CFG_POSC_MODE_LSB   3
`define CFG_POWER_UP_TIMER_ZERO_BIT   5
`define CFG_XTAL_BIT        6
`define IRQ_BOR_BIT         0
`define IRQ_RELEASE_BIT     1
`define TIMING_IDLE_BIT     3
`define TIMING_SLEEP_BIT    4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CONFIG_RESET        7'h00
`define CLK_PERIOD_NS       10
`define REG_STARTUP_US      20
`define REG_STARTUP_CYC     ((`REG_STARTUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAILSAFE_DELAY_US   100
`define FAILSAFE_CYC        ((`FAILSAFE_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_UP_TIMER_DEFAULT_CYC    16'h0400
`define OST_DEFAULT_CYC     16'h0400

`endif

/* File: reset_seq_pkg.sv */
// Purpose : Types shared by the reset sequencer
// Assumes : None
// Notes   : Constants live in the _regs header
package reset_seq_pkg;
    typedef enum logic [2:0] {
        ST_STARTUP = 3'b000,
        ST_CLKWAIT = 3'b001,
        ST_RUN     = 3'b010,
        ST_BORHOLD = 3'b011
    } seq_state_t;
endpackage

/* File: delay_counter.sv */
// Purpose : Loadable down-counter that flags when its interval has run out
// Assumes : Same clock as the sequencer
// Notes   : Used once per timed interval
`timescale 1ns/100ps
module delay_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              done
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         done_ff;
    logic         nxt_done;

    // Next count: load wins, then count down to zero
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_done = done_ff;
        if (load) begin
            nxt_cnt  = count;
            nxt_done = 1'b0;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end else begin
            nxt_done = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;
endmodule

/* File: brownout_reset_sequencer.sv */
// Purpose : Power-up / brown-out reset sequencing with Wishbone registers
// Assumes : clk_sys 100 MHz; analog inputs are asynchronous and synchronised here
// Notes   : Single clock domain; sys_rst models the power-on event
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "brownout_reset_sequencer_regs.svh"

module brownout_reset_sequencer #(
    parameter int        CW          = 16,
    parameter bit [15:0] POWER_UP_TIMER_CYC    = `POWER_UP_TIMER_DEFAULT_CYC,
    parameter bit [15:0] OST_CYC     = `OST_DEFAULT_CYC,
    parameter bit [15:0] STARTUP_CYC = 16'(`REG_STARTUP_CYC),
    parameter bit [15:0] FSCM_CYC    = 16'(`FAILSAFE_CYC)
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        core_supply_low,
    input  wire logic        power_down,
    input  wire logic        pll_locked,
    input  wire logic        sleep_mode,
    input  wire logic        idle_mode,
    output logic             exec_enable,
    output logic             sysclk_enable,
    output logic             core_reset,
    output logic [2:0]       clock_source,
    output logic             irq
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;

    // Two stages; first stage is read only by the second
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {pll_locked, power_down, core_supply_low};
            sync2_ff <= sync1_ff;
        end
    end

    logic bor_level;
    logic pd_level;
    logic lock_level;
    assign bor_level  = sync2_ff[0];
    assign pd_level   = sync2_ff[1];
    assign lock_level = sync2_ff[2];

    // ----------------------------------------
    // Registers and sequencer state
    // ----------------------------------------
    reset_seq_pkg::seq_state_t state_ff;
    reset_seq_pkg::seq_state_t nxt_state;
    logic [6:0]  config_ff;
    logic [6:0]  nxt_config;
    logic        bor_flag_ff;
    logic        nxt_bor_flag;
    logic        por_flag_ff;
    logic        nxt_por_flag;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  nxt_irq_stat;
    logic [1:0]  irq_mask_ff;
    logic [1:0]  nxt_irq_mask;
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [2:0]  clk_src_ff;
    logic [2:0]  nxt_clk_src;
    logic        pd_seen_ff;
    logic        nxt_pd_seen;
    logic        exec_ff;
    logic        nxt_exec;
    logic        core_rst_ff;
    logic        nxt_core_rst;
    logic        sysclk_en_ff;
    logic        nxt_sysclk_en;
    logic        irq_ff;
    logic        nxt_irq;
    logic        first_ff;

    logic        wr_stb;
    logic        rd_stb;
    logic        bor_event;
    logic        release_event;
    logic        load_start;
    logic        load_delays;
    logic        startup_done;
    logic        ost_done;
    logic        power_up_timer_done;
    logic        use_osc;
    logic        use_pll;
    logic        use_fscm;
    logic [15:0] power_up_timer_load;
    logic        clk_ready;

    // Single-cycle classic access; ack drops after one cycle
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
    assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;

    // Brown-out compare is not gated by low-power modes
    assign bor_event = bor_level && (state_ff != reset_seq_pkg::ST_BORHOLD);

    // Mode decode from config fields
    assign use_osc  = config_ff[`CFG_POSC_MODE_LSB +: 2] != 2'b11;
    assign use_pll  = config_ff[`CFG_OSC_SEL_LSB +: 3] == 3'b001
                   || config_ff[`CFG_OSC_SEL_LSB +: 3] == 3'b011;
    assign use_fscm = config_ff[`CFG_POWER_UP_TIMER_ZERO_BIT] && config_ff[`CFG_XTAL_BIT];
    // Fail-safe delay replaces the power-up delay
    assign power_up_timer_load = use_fscm ? FSCM_CYC
                     : (config_ff[`CFG_POWER_UP_TIMER_ZERO_BIT] ? 16'h0000 : POWER_UP_TIMER_CYC);

    // Clock held for start-up timer and PLL lock
    assign clk_ready = (!use_osc || ost_done) && (!use_pll || lock_level);

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    delay_counter #(.W(CW)) u_startup (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .load    (load_start),
        .count   (STARTUP_CYC),
        .done    (startup_done)
    );

    delay_counter #(.W(CW)) u_ost (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .load    (load_delays),
        .count   (OST_CYC),
        .done    (ost_done)
    );

    delay_counter #(.W(CW)) u_power_up_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .load    (load_delays),
        .count   (power_up_timer_load),
        .done    (power_up_timer_done)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Next-state logic; brown-out overrides every state except ST_BORHOLD
    always_comb begin
        nxt_state     = state_ff;
        nxt_clk_src   = clk_src_ff;
        nxt_pd_seen   = pd_seen_ff;
        load_start    = 1'b0;
        load_delays   = 1'b0;
        release_event = 1'b0;
        case (state_ff)
            reset_seq_pkg::ST_STARTUP: begin
                // Regulator start-up hold, execution off
                if (first_ff) begin
                    // Arm the hold on the first cycle out of power-on
                    load_start = 1'b1;
                end else if (startup_done && !pd_level) begin
                    nxt_state   = reset_seq_pkg::ST_CLKWAIT;
                    load_delays = 1'b1;
                end
            end
            reset_seq_pkg::ST_CLKWAIT: begin
                // Power-up delay runs in parallel; release needs both
                if (power_up_timer_done && clk_ready) begin
                    nxt_state     = reset_seq_pkg::ST_RUN;
                    release_event = 1'b1;
                end
            end
            reset_seq_pkg::ST_RUN: begin
                // Power-down remembered, start-up hold on wake
                if (pd_level) begin
                    nxt_pd_seen = 1'b1;
                end else if (pd_seen_ff) begin
                    nxt_pd_seen = 1'b0;
                    nxt_state   = reset_seq_pkg::ST_STARTUP;
                    load_start  = 1'b1;
                end
            end
            reset_seq_pkg::ST_BORHOLD: begin
                // Wait for supply recovery before sequencing again
                if (!bor_level) begin
                    nxt_state   = reset_seq_pkg::ST_CLKWAIT;
                    load_delays = 1'b1;
                end
            end
            default: begin
                nxt_state = reset_seq_pkg::ST_STARTUP;
            end
        endcase
        if (bor_event) begin
            nxt_state   = reset_seq_pkg::ST_BORHOLD;
            nxt_clk_src = config_ff[`CFG_OSC_SEL_LSB +: 3];
            nxt_pd_seen = 1'b0;
            load_start  = 1'b0;
            load_delays = 1'b0;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    // Write, clear and read decode; hardware set beats software clear
    always_comb begin
        nxt_config   = config_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_bor_flag = bor_flag_ff;
        nxt_por_flag = por_flag_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_rdata    = rdata_ff;
        nxt_ack      = wb_cyc_i && wb_stb_i && !ack_ff;
        if (wr_stb && wb_sel_i[0]) begin
            if (wb_adr_i == `REG_RESET_CTRL) begin
                // Flags clear only by software write of zero
                nxt_bor_flag = bor_flag_ff & wb_dat_i[`RESET_CTRL_BOR_BIT];
                nxt_por_flag = por_flag_ff & wb_dat_i[`RESET_CTRL_POR_BIT];
            end else if (wb_adr_i == `REG_CONFIG) begin
                nxt_config = wb_dat_i[6:0];
            end else if (wb_adr_i == `REG_IRQ_STATUS) begin
                nxt_irq_stat = irq_stat_ff & ~wb_dat_i[1:0];
            end else if (wb_adr_i == `REG_IRQ_MASK) begin
                nxt_irq_mask = wb_dat_i[1:0];
            end
        end
        if (bor_event) begin
            nxt_bor_flag                = 1'b1;
            nxt_irq_stat[`IRQ_BOR_BIT]  = 1'b1;
        end
        if (release_event) begin
            nxt_irq_stat[`IRQ_RELEASE_BIT] = 1'b1;
        end
        if (rd_stb) begin
            nxt_rdata = 32'h0000_0000;
            if (wb_adr_i == `REG_RESET_CTRL) begin
                nxt_rdata[`RESET_CTRL_BOR_BIT] = bor_flag_ff;
                nxt_rdata[`RESET_CTRL_POR_BIT] = por_flag_ff;
            end else if (wb_adr_i == `REG_OSC_CTRL) begin
                nxt_rdata[2:0]                = clk_src_ff;
                nxt_rdata[`OSC_CTRL_LOCK_BIT] = lock_level;
            end else if (wb_adr_i == `REG_CONFIG) begin
                nxt_rdata[6:0] = config_ff;
            end else if (wb_adr_i == `REG_IRQ_STATUS) begin
                nxt_rdata[1:0] = irq_stat_ff;
            end else if (wb_adr_i == `REG_IRQ_MASK) begin
                nxt_rdata[1:0] = irq_mask_ff;
            end else if (wb_adr_i == `REG_TIMING) begin
                nxt_rdata[2:0] = state_ff;
                // Low-power inputs come from same-clock core logic
                nxt_rdata[`TIMING_SLEEP_BIT] = sleep_mode;
                nxt_rdata[`TIMING_IDLE_BIT]  = idle_mode;
            end
        end
    end

    // Registers; power-on flag set by reset itself
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff    <= reset_seq_pkg::ST_STARTUP;
            config_ff   <= `CONFIG_RESET;
            bor_flag_ff <= 1'b0;
            por_flag_ff <= 1'b1;
            irq_stat_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
            ack_ff      <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            clk_src_ff  <= 3'h0;
            pd_seen_ff  <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            config_ff   <= nxt_config;
            bor_flag_ff <= nxt_bor_flag;
            por_flag_ff <= nxt_por_flag;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            ack_ff      <= nxt_ack;
            rdata_ff    <= nxt_rdata;
            clk_src_ff  <= nxt_clk_src;
            pd_seen_ff  <= nxt_pd_seen;
        end
    end

    // Power-on marker; high only in the first cycle after reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Outputs follow the next state, so the flops add no latency;
    // registering keeps reset and clock gate free of decode glitches
    always_comb begin
        nxt_exec      = (nxt_state == reset_seq_pkg::ST_RUN);
        nxt_core_rst  = (nxt_state != reset_seq_pkg::ST_RUN);
        nxt_sysclk_en = (nxt_state == reset_seq_pkg::ST_RUN)
                     || ((nxt_state == reset_seq_pkg::ST_CLKWAIT)
                         && clk_ready && !load_delays); // Stale done flags at entry
        nxt_irq       = |(nxt_irq_stat & nxt_irq_mask);
    end

    // Reset state: core held, clock stopped, no interrupt
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            exec_ff      <= 1'b0;
            core_rst_ff  <= 1'b1;
            sysclk_en_ff <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            exec_ff      <= nxt_exec;
            core_rst_ff  <= nxt_core_rst;
            sysclk_en_ff <= nxt_sysclk_en;
            irq_ff       <= nxt_irq;
        end
    end

    assign wb_ack_o      = ack_ff;
    assign wb_dat_o      = rdata_ff;
    assign exec_enable   = exec_ff;
    assign core_reset    = core_rst_ff;
    assign sysclk_enable = sysclk_en_ff;
    assign clock_source  = clk_src_ff;
    assign irq           = irq_ff;
endmodule

/* File: brownout_reset_sequencer_chk.sv */
// Purpose : Temporal checks on the reset sequencer ports
// Assumes : One clock, sync active-high reset
// Notes   : Bound to every sequencer instance
`timescale 1ns/100ps
module brownout_reset_sequencer_chk #(
    parameter bit [15:0] STARTUP_CYC = 16'h0014,
    parameter bit [15:0] POWER_UP_TIMER_CYC    = 16'h0010
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        core_supply_low,
    input wire logic        power_down,
    input wire logic        pll_locked,
    input wire logic        sleep_mode,
    input wire logic        idle_mode,
    input wire logic        exec_enable,
    input wire logic        sysclk_enable,
    input wire logic        core_reset,
    input wire logic [2:0]  clock_source,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // Cycles since power-on
    // ----------------------------------------
    logic [15:0] up_ff;
    logic [15:0] nxt_up;

    // Saturates so a long run never wraps
    always_comb begin
        nxt_up = (up_ff == 16'hFFFF) ? up_ff : up_ff + 16'h0001;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            up_ff <= 16'h0000;
        end else begin
            up_ff <= nxt_up;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_startup_hold: assert property (exec_enable |-> up_ff >= STARTUP_CYC + POWER_UP_TIMER_CYC - 2)
        else $error("execution enabled before start-up and power-up delay");
    a_exec_clean: assert property (exec_enable |-> !core_reset && sysclk_enable)
        else $error("execution with reset held or clock stopped");
    a_bor_reset: assert property ($rose(core_supply_low) |-> ##[1:4] core_reset)
        else $error("no reset after supply sag");
    a_bor_no_exec: assert property (core_supply_low [*5] |-> !exec_enable)
        else $error("execution during supply sag");
    a_clksrc_latch: assert property (!$stable(clock_source) |-> core_reset)
        else $error("clock source changed outside reset");
    a_pll_gate: assert property ($rose(sysclk_enable) && clock_source inside {3'h1, 3'h3}
        |-> $past(pll_locked, 2))
        else $error("clock released before lock");

    c_release: cover property ($rose(exec_enable));
    c_bor: cover property ($rose(core_supply_low) ##2 core_reset);
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind brownout_reset_sequencer brownout_reset_sequencer_chk #(
    .STARTUP_CYC(STARTUP_CYC), .POWER_UP_TIMER_CYC(POWER_UP_TIMER_CYC)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_supply_low(core_supply_low),
    .power_down(power_down), .pll_locked(pll_locked), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .exec_enable(exec_enable), .sysclk_enable(sysclk_enable),
    .core_reset(core_reset), .clock_source(clock_source), .irq(irq));

/* File: tb_brownout_reset_sequencer.sv */
// Purpose : Self-checking bench for the reset sequencer
// Assumes : Shortened delays via parameters
// Notes   : Wishbone classic single cycles only
`timescale 1ns/100ps
`include "brownout_reset_sequencer_regs.svh"
module tb_brownout_reset_sequencer;
    localparam int ST = 20;
    localparam int PW = 16;
    localparam int FS = 30;
    logic        clk_sys, sys_rst, cyc, stb, we, ack, low, pdn, lock, slp, idl;
    logic        exe, sck, crst, irq;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [2:0]  src;
    logic [6:0]  cfg [3] = '{7'h1A, 7'h62, 7'h00};
    int          lo [3] = '{PW, FS, PW};
    int          failures, total_checks, n;

    brownout_reset_sequencer #(.STARTUP_CYC(16'(ST)), .POWER_UP_TIMER_CYC(16'(PW)),
        .OST_CYC(16'h0010), .FSCM_CYC(16'(FS))) u_brownout_reset_sequencer (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .core_supply_low(low), .power_down(pdn), .pll_locked(lock),
        .sleep_mode(slp), .idle_mode(idl), .exec_enable(exe), .sysclk_enable(sck),
        .core_reset(crst), .clock_source(src), .irq(irq));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request held until ack is sampled high
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        check(nm, exp, q);
    endtask

    // Bounded wait so a stuck sequencer cannot hang the run
    task automatic wait_exec();
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (exe !== 1'b1 && n < 300);
    endtask

    task automatic sag();
        @(posedge clk_sys);
        low <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 6'h00; sel = 4'hF;
        wdat = 32'h0000_0000; low = 1'b0; pdn = 1'b0; lock = 1'b0; slp = 1'b0; idl = 1'b0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wait_exec();
        check("power-on delay", 32'h1, 32'(n >= ST + PW && n <= ST + PW + 8));
        rd(`REG_RESET_CTRL, 32'h0000_0001, "flags");
        bus(1'b1, 6'h18, 32'hFFFF_FFFF);
        rd(6'h18, 32'h0000_0000, "unmapped");
        $display("test power-on done");
        // Sag in sleep with the PLL selected and unlocked
        bus(1'b1, `REG_IRQ_MASK, 32'h0000_0001);
        bus(1'b1, `REG_CONFIG, 32'h0000_0001);
        slp <= 1'b1;
        sag();
        check("sag reset", 32'h2, {crst, exe});
        check("source", 32'h1, src);
        check("irq", 32'h1, irq);
        low <= 1'b0;
        repeat (40) @(posedge clk_sys);
        check("held for lock", 32'h0, exe);
        lock <= 1'b1;
        wait_exec();
        check("lock release", 32'h1, 32'(n <= 8));
        rd(`REG_RESET_CTRL, 32'h0000_0003, "flag kept");
        rd(`REG_OSC_CTRL, 32'h0000_0021, "osc");
        rd(`REG_TIMING, {27'h0, 2'b10, 3'(reset_seq_pkg::ST_RUN)}, "state sleep");
        bus(1'b1, `REG_RESET_CTRL, 32'h0000_0000);
        rd(`REG_RESET_CTRL, 32'h0000_0000, "flag cleared");
        bus(1'b1, `REG_IRQ_STATUS, 32'h0000_0003);
        check("irq cleared", 32'h0, irq);
        $display("test brown-out done");
        // Sags in idle with irq masked, across clock options
        slp <= 1'b0;
        idl <= 1'b1;
        bus(1'b1, `REG_IRQ_MASK, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, `REG_CONFIG, {25'h0, cfg[i]});
            sag();
            check("sag source", {29'h0, cfg[i][2:0]}, src);
            check("masked irq", 32'h0, irq);
            low <= 1'b0;
            wait_exec();
            check("release delay", 32'h1, 32'(n >= lo[i] && n <= lo[i] + 8));
        end
        rd(`REG_IRQ_STATUS, 32'h0000_0003, "status");
        $display("test options done");
        // Wake from power-down repeats the regulator hold
        pdn <= 1'b1;
        repeat (5) @(posedge clk_sys);
        pdn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("wake held", 32'h0, exe);
        wait_exec();
        check("wake delay", 32'h1, 32'(n + 4 >= ST + PW && n + 4 <= ST + PW + 10));
        $display("test power-down done");
        report_and_stop();
    end
endmodule
